// >>> src/clk_div_gen.v
/*
  Clock enable style divider: toggles a square wave output every
  half_i + 1 input cycles, so the period is 2 * (half_i + 1) core clocks.
  Assumes a single clock and a synchronous reset.
*/
`timescale 1ns/1ns
module clk_div_gen #(
  parameter W = 8
) (
  input wire clk_i,
  input wire rst_i,
  input wire [W-1:0] half_i,
  output reg wave_o,
  output reg rise_o
);
  reg [W-1:0] cnt_reg;

  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= {W{1'b0}};
      wave_o <= 1'b0;
      rise_o <= 1'b0;
    end else if (cnt_reg >= half_i) begin
      cnt_reg <= {W{1'b0}};
      wave_o <= ~wave_o;
      rise_o <= ~wave_o;
    end else begin
      cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
      rise_o <= 1'b0;
    end
  end
endmodule // clk_div_gen

// >>> src/clk_gate_defines.vh
/*
  Shared constants for the clock output gating and select block:
  strap timing, divider encodings and the serial override register layout.
  Assumes a 250 MHz core clock.
*/
`ifndef CLK_GATE_DEFINES_VH
`define CLK_GATE_DEFINES_VH

`define CLK_PERIOD_PS 4000
`define STRAP_TIME_US 2000
`define STRAP_CYCLES ((`STRAP_TIME_US * 1000000) / `CLK_PERIOD_PS)

`define STOP_LAT_MIN 2
`define STOP_LAT_MAX 3

`define PCI_DIV2 2'b00
`define PCI_DIV3 2'b01
`define PCI_DIV4 2'b10

`define REG_SELECT 32'h0000_0000
`define REG_STATUS 32'h0000_0004
`define SEL_CODE_LSB 0
`define SEL_OVR_BIT 4
`define SEL_RESET 5'h00

`endif

// >>> src/clk_out_gate.v
/*
  Glitch-free output gate: the enable is only changed while the source
  is low, so a stop always finishes a whole cycle and a start always
  begins with a whole one. Assumes the source is a core-clock square wave.
*/
`timescale 1ns/1ns
module clk_out_gate (
  input wire clk_i,
  input wire rst_i,
  input wire src_i,
  input wire run_i,
  output reg out_o
);
  reg en_reg;

  always @(posedge clk_i) begin
    if (rst_i) begin
      en_reg <= 1'b0;
      out_o <= 1'b0;
    end else begin
      // Enable moves only at the low phase, so no runt pulse appears
      if (!src_i) begin
        en_reg <= run_i;
      end
      out_o <= src_i & (src_i ? en_reg : run_i) & en_reg;
    end
  end
endmodule // clk_out_gate

// >>> src/clock_output_gating_select.v
/*
  Digital control of a system clock synthesizer: strap capture, frequency
  select decode, stop gating of processor, PCI and interrupt clocks, and
  choice of role for the shared reference pin. Clocks are modelled as
  square waves derived from the 250 MHz core clock; real frequencies come
  from the analog synthesizer, so divider settings here are scaled models.
  Registers are reached over classic Wishbone.
*/
// Our own choices: the Wishbone register port and the address map.
// What this block does
// - Four-bit select code picks processor frequency; PCI is processor over 2, 3 or 4.
// - Dual-function pins are sampled at power-up as select bits, then drive clocks.
// - USB reference output runs at fixed 48 MHz regardless of select code.
// - Super I/O clock output runs at fixed 24 MHz regardless of select code.
// - Stoppable processor clock is gated by the active-low clock-stop input.
// - On stop, finish current full cycle then hold low; latency two to three clocks.
// - On start, resume with a whole cycle, two to three clocks latency, no runt.
// - Interrupt-controller clock runs at reference rate, off while clock-stop is low.
// - PCI outputs two to five are gated by the active-low PCI-stop input.
// - First stoppable PCI output, shared with a strap, is gated by PCI-stop.
// - Free-running PCI output keeps toggling whatever PCI-stop does.
// - PCI-stop high lets stoppable PCI outputs run; low holds them at 0.
// - PCI-stop sampled on free-running PCI rising edge, acts next PCI cycle.
// - Mode strap on free-running PCI pin is sampled at power-up.
// - Mode 0 makes shared pin the PCI-stop input; mode 1 a reference output.
// - Reference pins acting as outputs carry the reference frequency.
// - Strap pins stay three-stated for 2 ms, are latched, then drivers enable.
// - Latched strap bits persist until power is cycled; nothing else clears them.
`timescale 1ns/1ns
`include "clk_gate_defines.vh"
module clock_output_gating_select #(
  parameter STRAP_CYCLES = `STRAP_CYCLES,
  parameter REF_HALF = 8'd8,
  parameter USB48_HALF = 8'd2,
  parameter SIO24_HALF = 8'd5
) (
  input wire clk_i,
  input wire rst_i,
  input wire por_i,
  input wire clk_stop_n_i,
  input wire freq_select_bit0_i,
  input wire freq_select_bit1_i,
  input wire freq_select_bit2_i,
  input wire freq_select_bit3_i,
  input wire mode_strap_i,
  input wire ref_clk_out0_pin_i,
  input wire [31:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire wb_we_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg cpu_clk_free_o,
  output wire cpu_clk_gated_o,
  output reg pci_clk_free_o,
  output reg pci_clk_free_oe_o,
  output reg pci_clk_gated_first_o,
  output reg pci_clk_gated_first_oe_o,
  output wire [3:0] pci_clk_gated_group_o,
  output wire irq_ctrl_clk_o,
  output reg usb_clk_o,
  output reg usb_clk_oe_o,
  output reg sio_clk_o,
  output reg sio_clk_oe_o,
  output reg ref_clk_out0_o,
  output reg ref_clk_out0_oe_o,
  output reg ref_clk_out1_o,
  output reg ref_clk_out1_oe_o,
  output reg [3:0] freq_select_code_o
);
  reg [31:0] strap_cnt_reg;
  reg strap_done_reg;
  reg [3:0] strap_code_reg;
  reg mode_reg;
  reg [4:0] sel_reg;
  reg [7:0] cpu_half_reg;
  reg [1:0] pci_div_reg;
  reg [2:0] pci_phase_reg;
  reg pci_wave_reg;
  reg pci_rise_reg;
  reg pci_first_en_reg;
  reg pci_run_reg;
  reg [1:0] stop_pipe_reg;
  reg irq_en_reg;
  reg irq_out_reg;
  wire [3:0] code_w;
  wire cpu_wave_w;
  wire cpu_rise_w;
  wire ref_wave_w;
  wire usb_wave_w;
  wire sio_wave_w;
  wire pci_stop_n_w;
  reg [7:0] cpu_half_next;
  reg [1:0] pci_div_next;
  reg [2:0] pci_last_w;

  // Serial override beats the straps only when its enable bit is set
  assign code_w = sel_reg[`SEL_OVR_BIT] ? sel_reg[3:0] : strap_code_reg;

  // Strap window counts from the power-good reset, not the system reset
  always @(posedge clk_i) begin
    if (por_i) begin
      strap_cnt_reg <= 32'h0000_0000;
      strap_done_reg <= 1'b0;
      strap_code_reg <= 4'h0;
      mode_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      if (strap_cnt_reg >= STRAP_CYCLES - 1) begin
        strap_done_reg <= 1'b1;
        strap_code_reg <= {freq_select_bit3_i, freq_select_bit2_i,
                           freq_select_bit1_i, freq_select_bit0_i};
        mode_reg <= mode_strap_i;
      end else begin
        strap_cnt_reg <= strap_cnt_reg + 32'h0000_0001;
      end
    end
    // Once done, only por_i clears the straps; rst_i does not
  end

  // Select table, scaled: cpu half period and pci divider
  always @* begin
    cpu_half_next = 8'd1;
    pci_div_next = `PCI_DIV3;
    case (code_w)
      4'hf, 4'he, 4'hd, 4'hc: begin
        cpu_half_next = 8'd0;
        pci_div_next = `PCI_DIV4;
      end
      4'h3, 4'h2, 4'h1: begin
        cpu_half_next = 8'd2;
        pci_div_next = `PCI_DIV2;
      end
      default: begin
        cpu_half_next = 8'd1;
        pci_div_next = `PCI_DIV3;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      cpu_half_reg <= 8'd1;
      pci_div_reg <= `PCI_DIV3;
    end else begin
      cpu_half_reg <= cpu_half_next;
      pci_div_reg <= pci_div_next;
    end
  end

  clk_div_gen #(.W(8)) cpu_div (
    .clk_i(clk_i), .rst_i(rst_i), .half_i(cpu_half_reg),
    .wave_o(cpu_wave_w), .rise_o(cpu_rise_w)
  );
  clk_div_gen #(.W(8)) ref_div (
    .clk_i(clk_i), .rst_i(rst_i), .half_i(REF_HALF), .wave_o(ref_wave_w), .rise_o()
  );
  clk_div_gen #(.W(8)) usb_div (
    .clk_i(clk_i), .rst_i(rst_i), .half_i(USB48_HALF), .wave_o(usb_wave_w), .rise_o()
  );
  clk_div_gen #(.W(8)) sio_div (
    .clk_i(clk_i), .rst_i(rst_i), .half_i(SIO24_HALF), .wave_o(sio_wave_w), .rise_o()
  );

  // PCI wave: one period per 2, 3 or 4 processor periods
  always @* begin
    case (pci_div_reg)
      `PCI_DIV2: pci_last_w = 3'd1;
      `PCI_DIV4: pci_last_w = 3'd3;
      default: pci_last_w = 3'd2;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      pci_phase_reg <= 3'd0;
      pci_wave_reg <= 1'b0;
      pci_rise_reg <= 1'b0;
    end else begin
      pci_rise_reg <= 1'b0;
      if (cpu_rise_w) begin
        if (pci_phase_reg >= pci_last_w) begin
          pci_phase_reg <= 3'd0;
          pci_wave_reg <= 1'b1;
          pci_rise_reg <= 1'b1;
        end else begin
          pci_phase_reg <= pci_phase_reg + 3'd1;
          // Low half starts at mid-period, rounded up for odd ratios
          if (pci_phase_reg + 3'd1 >= ((pci_last_w + 3'd2) >> 1)) begin
            pci_wave_reg <= 1'b0;
          end
        end
      end
    end
  end

  // PCI-stop exists only in mode 0; in mode 1 the pin is an output
  assign pci_stop_n_w = mode_reg ? 1'b1 : ref_clk_out0_pin_i;

  // Sample on the free PCI rise; the low-phase gates apply it from the next PCI cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      pci_run_reg <= 1'b1;
    end else if (pci_rise_reg) begin
      pci_run_reg <= pci_stop_n_w;
    end
  end

  // Two stages stepped on processor clock rises give the 2-3 processor clock latency band
  always @(posedge clk_i) begin
    if (rst_i) begin
      stop_pipe_reg <= 2'b11;
    end else if (cpu_rise_w) begin
      stop_pipe_reg <= {stop_pipe_reg[0], clk_stop_n_i};
    end
  end

  clk_out_gate cpu_gate (
    .clk_i(clk_i), .rst_i(rst_i), .src_i(cpu_wave_w),
    .run_i(stop_pipe_reg[1]), .out_o(cpu_clk_gated_o)
  );

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : pci_grp
      clk_out_gate pci_gate (
        .clk_i(clk_i), .rst_i(rst_i), .src_i(pci_wave_reg),
        .run_i(pci_run_reg), .out_o(pci_clk_gated_group_o[g])
      );
    end
  endgenerate

  // Interrupt clock off while clock-stop is low, whole cycles only
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_en_reg <= 1'b0;
      irq_out_reg <= 1'b0;
    end else begin
      if (!ref_wave_w) begin
        irq_en_reg <= clk_stop_n_i;
      end
      irq_out_reg <= ref_wave_w & irq_en_reg & (ref_wave_w ? 1'b1 : clk_stop_n_i);
    end
  end
  assign irq_ctrl_clk_o = irq_out_reg;

  // Pin drivers, all from flops; straps held three-stated until latched
  always @(posedge clk_i) begin
    if (rst_i) begin
      cpu_clk_free_o <= 1'b0;
      pci_clk_free_o <= 1'b0;
      pci_clk_gated_first_o <= 1'b0;
      pci_first_en_reg <= 1'b0;
      usb_clk_o <= 1'b0;
      sio_clk_o <= 1'b0;
      ref_clk_out0_o <= 1'b0;
      ref_clk_out1_o <= 1'b0;
      pci_clk_free_oe_o <= 1'b0;
      pci_clk_gated_first_oe_o <= 1'b0;
      usb_clk_oe_o <= 1'b0;
      sio_clk_oe_o <= 1'b0;
      ref_clk_out0_oe_o <= 1'b0;
      ref_clk_out1_oe_o <= 1'b0;
      freq_select_code_o <= 4'h0;
    end else begin
      cpu_clk_free_o <= cpu_wave_w;
      pci_clk_free_o <= pci_wave_reg;
      // Same low-phase enable as the group, so the strap pin never shows a runt
      if (!pci_wave_reg) begin
        pci_first_en_reg <= pci_run_reg;
      end
      pci_clk_gated_first_o <= pci_wave_reg & pci_first_en_reg;
      usb_clk_o <= usb_wave_w;
      sio_clk_o <= sio_wave_w;
      ref_clk_out0_o <= ref_wave_w & mode_reg;
      ref_clk_out1_o <= ref_wave_w;
      pci_clk_free_oe_o <= strap_done_reg;
      pci_clk_gated_first_oe_o <= strap_done_reg;
      usb_clk_oe_o <= strap_done_reg;
      sio_clk_oe_o <= strap_done_reg;
      ref_clk_out1_oe_o <= strap_done_reg;
      ref_clk_out0_oe_o <= strap_done_reg & mode_reg;
      freq_select_code_o <= code_w;
    end
  end

  // Wishbone slave: one wait state, ack drops the cycle after it rose
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      sel_reg <= `SEL_RESET;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= 32'h0000_0000;
      // Write lands at the edge where the master sees ack, not before
      if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] &&
          wb_adr_i == `REG_SELECT) begin
        sel_reg <= wb_dat_i[4:0];
      end
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        if (wb_adr_i == `REG_SELECT) begin
          wb_dat_o <= {27'h0000000, sel_reg};
        end else if (wb_adr_i == `REG_STATUS) begin
          wb_dat_o <= {24'h000000, 1'b0, stop_pipe_reg[1], pci_run_reg, mode_reg,
                       strap_done_reg ? strap_code_reg : 4'h0};
        end
      end
    end
  end
endmodule // clock_output_gating_select

// >>> testbench/clk_gate_assertions.sv
/* Port checker for the clock gating and select block.
   Assumes one core clock and a synchronous reset. */
`timescale 1ns/1ns
module clk_gate_assertions (
  input wire clk_i,
  input wire rst_i,
  input wire por_i,
  input wire clk_stop_n_i,
  input wire ref_clk_out0_pin_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire cpu_clk_free_o,
  input wire cpu_clk_gated_o,
  input wire irq_ctrl_clk_o,
  input wire pci_clk_free_o,
  input wire pci_clk_free_oe_o,
  input wire pci_clk_gated_first_o,
  input wire pci_clk_gated_first_oe_o,
  input wire [3:0] pci_clk_gated_group_o,
  input wire usb_clk_oe_o,
  input wire ref_clk_out0_oe_o,
  input wire [3:0] freq_select_code_o
);
  reg [7:0] stop_reg, pstop_reg, cfree_reg, pfree_reg;
  reg cpu_reg, pci_reg;
  function automatic [7:0] inc(input [7:0] v);
    inc = v + {7'h00, v != 8'hff};
  endfunction
  // Saturating counters keep long waits out of the properties
  always @(posedge clk_i) begin
    cpu_reg <= cpu_clk_free_o;
    pci_reg <= pci_clk_free_o;
    stop_reg <= (rst_i || clk_stop_n_i) ? 8'h00 : inc(stop_reg);
    pstop_reg <= (rst_i || ref_clk_out0_pin_i) ? 8'h00 : inc(pstop_reg);
    cfree_reg <= (rst_i || cpu_clk_free_o != cpu_reg) ? 8'h00 : inc(cfree_reg);
    pfree_reg <= (rst_i || pci_clk_free_o != pci_reg) ? 8'h00 : inc(pfree_reg);
  end
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held over one cycle");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  cpu_stop_low_a: assert property (stop_reg >= 8'd100 |-> !cpu_clk_gated_o && !irq_ctrl_clk_o)
    else $error("stopped clock not low");
  cpu_free_runs_a: assert property (cfree_reg < 8'd200)
    else $error("free processor clock stuck");
  pci_free_runs_a: assert property (pci_clk_free_oe_o |-> pfree_reg < 8'd200)
    else $error("free pci clock stuck");
  pci_stop_low_a: assert property (pci_clk_gated_first_oe_o && !ref_clk_out0_oe_o
    && pstop_reg >= 8'd100 |-> pci_clk_gated_group_o == 4'h0 && !pci_clk_gated_first_o)
    else $error("stopped pci clocks not low");
  strap_float_a: assert property (por_i |=> !usb_clk_oe_o && !pci_clk_free_oe_o)
    else $error("driver on during strap window");
  code_hold_a: assert property ($past(usb_clk_oe_o, 2) && !$past(wb_cyc_i)
    && !$past(wb_cyc_i, 2) && !$past(por_i) |-> $stable(freq_select_code_o))
    else $error("select code moved without a write");
endmodule // clk_gate_assertions

bind clock_output_gating_select clk_gate_assertions u_chk (.clk_i, .rst_i, .por_i,
  .clk_stop_n_i, .ref_clk_out0_pin_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .cpu_clk_free_o,
  .cpu_clk_gated_o, .irq_ctrl_clk_o, .pci_clk_free_o, .pci_clk_free_oe_o,
  .pci_clk_gated_first_o, .pci_clk_gated_first_oe_o, .pci_clk_gated_group_o,
  .usb_clk_oe_o, .ref_clk_out0_oe_o, .freq_select_code_o);

// >>> testbench/clk_sink_model.sv
/* Clock receivers: count rising edges and the shortest high phase per line.
   Assumes lines are square waves on the core clock. */
`timescale 1ns/1ns
module clk_sink_model (
  input wire clk_i,
  input wire clr_i,
  input wire [7:0] line_i,
  output int edges_o [8],
  output int min_hi_o [8]
);
  logic [7:0] last_reg = 8'h00;
  int hi_cnt [8];
  // A short high phase shows up as a runt in min_hi_o
  always @(posedge clk_i) begin
    for (int i = 0; i < 8; i++) begin
      if (line_i[i] && !last_reg[i]) edges_o[i] <= edges_o[i] + 1;
      hi_cnt[i] <= line_i[i] ? hi_cnt[i] + 1 : 0;
      if (clr_i) min_hi_o[i] <= 999;
      else if (!line_i[i] && last_reg[i] && hi_cnt[i] < min_hi_o[i]) min_hi_o[i] <= hi_cnt[i];
    end
    last_reg <= line_i;
  end
endmodule // clk_sink_model

// >>> testbench/clock_output_gating_select_tb_top.sv
/* Testbench for the clock gating and select block.
   Assumes the strap window is shortened to 20 core clocks. */
`timescale 1ns/1ns
module clock_output_gating_select_tb_top;
  logic clk_i = 0, rst_i = 1, por_i = 1, clk_stop_n_i = 1, mode_strap_i = 0;
  logic ref_clk_out0_pin_i = 1, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0, clr = 0;
  logic [3:0] wb_sel_i = 4'h1, strap = 4'ha;
  logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, rd;
  wire [31:0] wb_dat_o;
  wire [3:0] pci_clk_gated_group_o, freq_select_code_o;
  wire wb_ack_o, cpu_clk_free_o, cpu_clk_gated_o, pci_clk_free_o, pci_clk_free_oe_o;
  wire pci_clk_gated_first_o, pci_clk_gated_first_oe_o, irq_ctrl_clk_o, usb_clk_o;
  wire usb_clk_oe_o, sio_clk_o, sio_clk_oe_o, ref_clk_out0_o, ref_clk_out0_oe_o;
  wire ref_clk_out1_o, ref_clk_out1_oe_o;
  wire freq_select_bit0_i = strap[0];
  wire freq_select_bit1_i = strap[1];
  wire freq_select_bit2_i = strap[2];
  wire freq_select_bit3_i = strap[3];
  int miscompares = 0, total_checks = 0, cycles = 0, usb_ref = 0, f;
  int e [8], m [8], e2 [8], r1, i5;
  clock_output_gating_select #(.STRAP_CYCLES(20)) u_dut (.*);
  clk_sink_model u_sink (.clk_i(clk_i), .clr_i(clr), .edges_o(e), .min_hi_o(m),
    .line_i({ref_clk_out0_o, usb_clk_o, irq_ctrl_clk_o, pci_clk_gated_group_o[0],
    pci_clk_gated_first_o, pci_clk_free_o, cpu_clk_gated_o, cpu_clk_free_o}));
  clk_sink_model u_sink2 (.clk_i(clk_i), .clr_i(clr), .edges_o(e2), .min_hi_o(),
    .line_i({6'h00, ref_clk_out1_o, sio_clk_o}));
  always #2 clk_i = ~clk_i;
  // Whole plan needs about 3200 cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wb(input logic we, input logic [31:0] adr, input logic [31:0] dat);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    // Only ack or the bench timeout ends this wait
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    tick(1);
  endtask
  task automatic power_up(input logic md, input logic [3:0] code);
    strap <= code;
    mode_strap_i <= md;
    por_i <= 1'b1;
    rst_i <= 1'b1;
    tick(5);
    rst_i <= 1'b0;
    tick(2);
    por_i <= 1'b0;
    tick(1);
    chk({31'h0, usb_clk_oe_o}, 32'h0);
    tick(30);
    chk({28'h0, freq_select_code_o}, {28'h0, code});
    wb(1'b0, 32'h4, 32'h0);
    chk(rd & 32'h1f, {27'h0, md, code});
    chk({31'h0, ref_clk_out0_oe_o}, {31'h0, md});
    chk({30'h0, usb_clk_oe_o, sio_clk_oe_o}, 32'h3);
    chk({29'h0, ref_clk_out1_oe_o, pci_clk_free_oe_o, pci_clk_gated_first_oe_o}, 32'h7);
  endtask
  task automatic t_hold();
    strap <= 4'h5;
    mode_strap_i <= 1'b1;
    rst_i <= 1'b1;
    tick(5);
    rst_i <= 1'b0;
    tick(30);
    chk({28'h0, freq_select_code_o}, 32'ha);
    chk({31'h0, ref_clk_out0_oe_o}, 32'h0);
    wb(1'b1, 32'h8, 32'hffff_ffff);
    wb(1'b0, 32'h8, 32'h0);
    chk(rd, 32'h0);
  endtask
  task automatic t_ratio(input logic [3:0] code, input int div);
    int c, p, u, s;
    wb(1'b1, 32'h0, {27'h0, 1'b1, code});
    wb(1'b0, 32'h0, 32'h0);
    chk(rd & 32'h1f, {27'h0, 1'b1, code});
    chk({28'h0, freq_select_code_o}, {28'h0, code});
    tick(20);
    c = e[0];
    p = e[2];
    u = e[6];
    s = e2[0];
    tick(600);
    c = e[0] - c;
    p = e[2] - p;
    u = e[6] - u;
    s = e2[0] - s;
    chk({31'h0, c - div * p <= div && div * p - c <= div && p > 0}, 32'h1);
    if (usb_ref == 0) usb_ref = u;
    chk({31'h0, u - usb_ref <= 1 && usb_ref - u <= 1}, 32'h1);
    chk({31'h0, u - 2 * s <= 2 && 2 * s - u <= 2 && s > 0}, 32'h1);
  endtask
  task automatic t_cpu_stop();
    int g, q;
    clr <= 1'b1;
    tick(1);
    clr <= 1'b0;
    clk_stop_n_i <= 1'b0;
    // Four processor periods at code 3 bound the stop latency
    tick(24);
    g = e[1];
    q = e[5];
    f = e[0];
    tick(100);
    chk(e[1] - g + e[5] - q, 0);
    chk({31'h0, e[0] > f}, 32'h1);
    clk_stop_n_i <= 1'b1;
    tick(150);
    chk({31'h0, e[1] > g && e[5] > q}, 32'h1);
    chk(m[1], m[0]);
  endtask
  task automatic t_pci_stop();
    int a, b;
    ref_clk_out0_pin_i <= 1'b0;
    // Two PCI periods at code 3: sample at one rise, stopped from the next cycle
    tick(24);
    a = e[3];
    b = e[4];
    f = e[2];
    tick(100);
    chk(e[3] - a + e[4] - b, 0);
    chk({27'h0, pci_clk_gated_group_o, pci_clk_gated_first_o}, 32'h0);
    chk({31'h0, e[2] > f}, 32'h1);
    ref_clk_out0_pin_i <= 1'b1;
    tick(100);
    chk({31'h0, e[3] > a && e[4] > b}, 32'h1);
    chk(m[3], m[2]);
    chk(m[4], m[2]);
  endtask
  initial begin
    power_up(1'b0, 4'ha);
    t_hold();
    t_ratio(4'hf, 4);
    t_ratio(4'h8, 3);
    t_ratio(4'h0, 3);
    t_ratio(4'h3, 2);
    t_cpu_stop();
    t_pci_stop();
    power_up(1'b1, 4'h3);
    f = e[7];
    r1 = e2[1];
    i5 = e[5];
    tick(100);
    chk({31'h0, e[7] > f}, 32'h1);
    chk(e2[1] - r1, e[7] - f);
    chk(e[5] - i5, e[7] - f);
    close_out();
  end
endmodule // clock_output_gating_select_tb_top
